// file: alert_pkg.sv
// Package: status and alert aggregator constants and carriers
package alert_pkg;
	localparam int unsigned lat_count = 32;
	localparam int unsigned grp_count = 4;
	localparam int unsigned grp_width = 8;
	localparam int unsigned adr_width = 4;
	localparam logic [3:0] adr_status0 = 4'h0;
	localparam logic [3:0] adr_status1 = 4'h1;
	localparam logic [3:0] adr_status2 = 4'h2;
	localparam logic [3:0] adr_status3 = 4'h3;
	localparam logic [3:0] adr_mask0 = 4'h4;
	localparam logic [3:0] adr_mask1 = 4'h5;
	localparam logic [3:0] adr_mask2 = 4'h6;
	localparam logic [3:0] adr_mask3 = 4'h7;
	localparam logic [3:0] adr_summary = 4'h8;
	localparam logic [3:0] adr_ctrl = 4'h9;
	localparam int unsigned ctrl_clear_all_bit = 0;
	localparam int unsigned sum_off_bit = 4;
	localparam int unsigned sum_pgood_n_bit = 5;
	localparam int unsigned sum_alert_bit = 6;
	localparam logic [31:0] lat_reset = 32'h0000_0000;
	localparam logic [31:0] mask_reset = 32'h0000_0000;
	localparam logic [7:0] rd_unmapped = 8'h00;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic clear_faults;
		logic ara_done;
		logic output_cycle;
	} host_evt_s;

	typedef enum logic [1:0] {
		alert_idle = 2'b01,
		alert_low = 2'b10
	} alert_state_e;
endpackage

// file: status_latch_bank.sv
// Status latch bank: sticky per-bit latches, set wins over pulsed clear
`timescale 1ns/1ps
module status_latch_bank #(
	parameter int unsigned WIDTH = 32
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Events and clears
	input wire logic [WIDTH-1:0] event_in,
	input wire logic [WIDTH-1:0] clr_pulse,
	// Latch outputs
	output logic [WIDTH-1:0] lat_q,
	output logic [WIDTH-1:0] lat_rise
);
	import alert_pkg::*;
	logic [WIDTH-1:0] lat_r;
	logic [WIDTH-1:0] lat_nxt;
	logic [WIDTH-1:0] rise_r;
	logic [WIDTH-1:0] rise_nxt;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lat
			always_comb begin
				// Clear is only a pulse, a live event re-sets at once
				lat_nxt[i] = event_in[i] | (lat_r[i] & ~clr_pulse[i]);
				// Re-set after a clear is a fresh edge, else a lasting fault never re-alerts
				rise_nxt[i] = event_in[i] & (~lat_r[i] | clr_pulse[i]);
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (srst) begin
			lat_r <= WIDTH'(lat_reset);
			rise_r <= '0;
		end else begin
			lat_r <= lat_nxt;
			rise_r <= rise_nxt;
		end
	end

	assign lat_q = lat_r;
	assign lat_rise = rise_r;

	a_set_wins: assert property (@(posedge core_clk) disable iff (srst)
		(event_in != '0) |=> ((lat_r & $past(event_in)) == $past(event_in)))
		else $error("event lost against a clear");
	a_sticky_hold: assert property (@(posedge core_clk) disable iff (srst)
		(clr_pulse == '0) |=> ((lat_r & $past(lat_r)) == $past(lat_r)))
		else $error("latch dropped without a clear");
	a_reset_rises: assert property (@(posedge core_clk) disable iff (srst)
		((event_in & clr_pulse) != '0)
		|=> ((rise_r & $past(event_in & clr_pulse)) == $past(event_in & clr_pulse)))
		else $error("re-set after clear gave no edge");
endmodule // status_latch_bank

// file: status_alert_aggregator.sv
// Status latches, summary bits and active-low alert line
//
// Contract
// - A detected event sets its status latch; the latch forms the status bit.
// - Each of summary bits 0 to 3 is the OR of its group of status bits.
// - Summary clears with the last contributing bit, stays while any remains.
// - Off and power-good-low summary bits follow live state, never cleared.
// - A still-active event re-sets its bit at once and re-raises alert.
// - The mask lets the host stop re-alerts from a lasting condition.
// - A set mask bit blocks its latch from the alert circuit.
// - A clear mask bit passes its latch to the alert circuit.
// - Alert asserts low on a rising edge of an unmasked latch.
// - Alert stays low until cleared; address sent to alert response releases it.
// - Clear-faults command releases the alert line.
// - Writing a one to a status bit resets that latch.
// - Every clear is a one-cycle pulse on the latch.
// - A lasting event never reads back as cleared.
// - Status write: ones clear set bits, zeros leave bits alone.
// - Latches stay set until cleared, clear-faults, output off-on, or reset.
// - Summary register takes no write-one clear.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module status_alert_aggregator #(
	parameter int unsigned LATCHES = 32
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Event detectors and live state, same clock domain
	input wire logic [LATCHES-1:0] event_in,
	input wire logic off_state,
	input wire logic pgood_n_state,
	// Host transaction engine strobes
	input wire alert_pkg::host_evt_s host_evt,
	// Register port
	input wire alert_pkg::reg_req_s reg_req,
	output logic [7:0] rd_data,
	// Alert line and interrupt
	output logic alert_out_n,
	output logic irq
);
	import alert_pkg::*;

	logic [LATCHES-1:0] lat_q;
	logic [LATCHES-1:0] lat_rise;
	logic [LATCHES-1:0] clr_pulse;
	logic [LATCHES-1:0] mask_r;
	logic [LATCHES-1:0] mask_nxt;
	logic [LATCHES-1:0] gated;
	logic [grp_count-1:0] grp_or;
	logic [7:0] summary;
	logic [7:0] rd_r;
	logic [7:0] rd_nxt;
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	alert_state_e st_r;
	alert_state_e st_nxt;
	logic alert_n_r;
	logic alert_n_nxt;
	logic irq_r;
	logic irq_nxt;
	logic edge_any;
	logic release_evt;

	// Write-one-to-clear decode, one pulse per access
	always_comb begin
		clr_pulse = '0;
		if (reg_req.wr && reg_req.addr < 4'(grp_count)) begin
			for (int g = 0; g < int'(grp_count); g++) begin
				if (reg_req.addr == 4'(g)) begin
					clr_pulse[g*grp_width +: grp_width] = reg_req.wdata;
				end
			end
		end
		// Global clears hit every latch for one cycle only
		if (host_evt.clear_faults || host_evt.output_cycle) begin
			clr_pulse = '1;
		end
		if (reg_req.wr && reg_req.addr == adr_ctrl && reg_req.wdata[ctrl_clear_all_bit]) begin
			clr_pulse = '1;
		end
	end

	status_latch_bank #(
		.WIDTH(LATCHES)
	) u_bank (
		.core_clk(core_clk),
		.srst(srst),
		.event_in(event_in),
		.clr_pulse(clr_pulse),
		.lat_q(lat_q),
		.lat_rise(lat_rise)
	);

	// Summary is pure combinational OR, so it drops with the last bit
	genvar gi;
	generate
		for (gi = 0; gi < grp_count; gi++) begin : g_sum
			assign grp_or[gi] = |lat_q[gi*grp_width +: grp_width];
		end
	endgenerate

	always_comb begin
		summary = '0;
		summary[grp_count-1:0] = grp_or;
		summary[sum_off_bit] = off_state;
		summary[sum_pgood_n_bit] = pgood_n_state;
		summary[sum_alert_bit] = ~alert_n_r;
	end

	// Mask register, and its gate ahead of the alert circuit
	always_comb begin
		mask_nxt = mask_r;
		if (reg_req.wr) begin
			for (int g = 0; g < int'(grp_count); g++) begin
				if (reg_req.addr == adr_mask0 + 4'(g)) begin
					mask_nxt[g*grp_width +: grp_width] = reg_req.wdata;
				end
			end
		end
		ctrl_nxt = ctrl_r;
		if (reg_req.wr && reg_req.addr == adr_ctrl) begin
			ctrl_nxt = reg_req.wdata & ~8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			mask_r <= LATCHES'(mask_reset);
			ctrl_r <= 8'h00;
		end else begin
			mask_r <= mask_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	assign gated = lat_rise & ~mask_r;
	assign edge_any = |gated;
	assign release_evt = host_evt.ara_done | host_evt.clear_faults;

	// Alert line state machine
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			alert_idle: begin
				if (edge_any) begin
					st_nxt = alert_low;
				end
			end
			alert_low: begin
				// A fresh edge in the release cycle keeps the line low
				if (release_evt && !edge_any) begin
					st_nxt = alert_idle;
				end
			end
			default: st_nxt = alert_idle;
		endcase
		alert_n_nxt = (st_nxt != alert_low);
		irq_nxt = (st_nxt == alert_low);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r <= alert_idle;
			alert_n_r <= 1'b1;
			irq_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			alert_n_r <= alert_n_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Read port; latch state already holds the re-set by the next cycle
	always_comb begin
		rd_nxt = 8'h00;
		if (reg_req.rd) begin
			if (reg_req.addr < 4'(grp_count)) begin
				rd_nxt = lat_q[reg_req.addr[1:0]*grp_width +: grp_width];
			end else if (reg_req.addr >= adr_mask0 && reg_req.addr <= adr_mask3) begin
				rd_nxt = mask_r[reg_req.addr[1:0]*grp_width +: grp_width];
			end else if (reg_req.addr == adr_summary) begin
				rd_nxt = summary;
			end else if (reg_req.addr == adr_ctrl) begin
				rd_nxt = ctrl_r;
			end else begin
				rd_nxt = rd_unmapped;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_r <= 8'h00;
		end else begin
			rd_r <= rd_nxt;
		end
	end

	assign rd_data = rd_r;
	assign alert_out_n = alert_n_r;
	assign irq = irq_r;

	a_edge_alerts: assert property (@(posedge core_clk) disable iff (srst)
		(edge_any) |=> !alert_out_n)
		else $error("unmasked edge did not pull alert low");
	a_mask_blocks: assert property (@(posedge core_clk) disable iff (srst)
		(alert_out_n && !edge_any) |=> alert_out_n)
		else $error("alert fell without unmasked edge");
	a_alert_holds: assert property (@(posedge core_clk) disable iff (srst)
		(!alert_out_n && !release_evt) |=> !alert_out_n)
		else $error("alert released without a clear");
	a_clear_faults: assert property (@(posedge core_clk) disable iff (srst)
		(host_evt.clear_faults && !edge_any) |=> alert_out_n)
		else $error("clear faults did not release alert");
	a_summary_or: assert property (@(posedge core_clk) disable iff (srst)
		summary[0] == (|lat_q[7:0]))
		else $error("summary bit differs from group OR");
	a_live_bits: assert property (@(posedge core_clk) disable iff (srst)
		summary[sum_off_bit] == off_state && summary[sum_pgood_n_bit] == pgood_n_state)
		else $error("live summary bit does not follow state");
	a_w1c_clears: assert property (@(posedge core_clk) disable iff (srst)
		(reg_req.wr && reg_req.addr == adr_status0 && event_in[7:0] == 8'h00)
		|=> ((lat_q[7:0] & $past(reg_req.wdata)) == 8'h00))
		else $error("write one did not clear latch");
	a_persist_read: assert property (@(posedge core_clk) disable iff (srst)
		(reg_req.rd && reg_req.addr == adr_status0 && event_in[0] && $past(event_in[0]))
		|=> rd_data[0])
		else $error("lasting event read as clear");
	a_reassert: assert property (@(posedge core_clk) disable iff (srst)
		(event_in[0] && !lat_q[0] && !mask_r[0] && !(reg_req.wr && reg_req.addr == adr_mask0))
		|=> ##1 !alert_out_n)
		else $error("re-set did not re-raise alert");
	a_zero_keeps: assert property (@(posedge core_clk) disable iff (srst)
		(reg_req.wr && reg_req.addr == adr_status0 && reg_req.wdata == 8'h00
			&& !host_evt.clear_faults && !host_evt.output_cycle)
		|=> ((lat_q[7:0] & $past(lat_q[7:0])) == $past(lat_q[7:0])))
		else $error("zero write changed a latch");

	c_alert_raise: cover property (@(posedge core_clk) disable iff (srst)
		alert_out_n ##1 !alert_out_n);
	c_ara_release: cover property (@(posedge core_clk) disable iff (srst)
		!alert_out_n && host_evt.ara_done ##1 alert_out_n);
	c_reassert: cover property (@(posedge core_clk) disable iff (srst)
		host_evt.clear_faults && event_in[0] ##2 !alert_out_n);
	c_masked_event: cover property (@(posedge core_clk) disable iff (srst)
		lat_rise[0] && mask_r[0] && alert_out_n);
endmodule // status_alert_aggregator

// file: host_model.sv
// Host-side model: register cycles and host event strobes
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic core_clk,
	// Register port
	output alert_pkg::reg_req_s reg_req,
	input wire logic [7:0] rd_data,
	// Host strobes
	output alert_pkg::host_evt_s host_evt
);
	import alert_pkg::*;
	initial begin
		reg_req = '0;
		host_evt = '0;
	end
	// Released lines show inverted values, never a stale copy
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk) reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk) reg_req <= '{~a, ~d, 1'b0, 1'b0};
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk) reg_req <= '{~a, 8'hff, 1'b0, 1'b0};
		#1 d = rd_data;
	endtask
	// Bits: clear_faults, ara_done, output_cycle
	task automatic pulse(input logic [2:0] k);
		@(posedge core_clk) host_evt <= k;
		@(posedge core_clk) host_evt <= '0;
		#1;
	endtask
endmodule // host_model

// file: status_alert_aggregator_tb_top.sv
// Self-checking bench for the status latch and alert aggregator
`timescale 1ns/1ps
module status_alert_aggregator_tb_top;
	import alert_pkg::*;
	logic core_clk;
	logic srst;
	logic [31:0] event_in;
	logic off_state;
	logic pgood_n_state;
	host_evt_s host_evt;
	reg_req_s reg_req;
	logic [7:0] rd_data;
	logic alert_out_n;
	logic irq;
	int failures;
	int comparisons;
	logic [31:0] lat_m;
	logic [7:0] m;
	int b;

	status_alert_aggregator #(.LATCHES(32)) dut (.core_clk(core_clk), .srst(srst),
		.event_in(event_in), .off_state(off_state), .pgood_n_state(pgood_n_state),
		.host_evt(host_evt), .reg_req(reg_req), .rd_data(rd_data),
		.alert_out_n(alert_out_n), .irq(irq));
	host_model hm (.core_clk(core_clk), .reg_req(reg_req), .rd_data(rd_data),
		.host_evt(host_evt));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		hm.rd(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask
	task automatic alert(input logic low);
		chk("alert_out_n", {7'h0, alert_out_n}, {7'h0, ~low});
		chk("irq", {7'h0, irq}, {7'h0, low});
	endtask
	function automatic logic [7:0] sum_of(input logic [31:0] l, input logic al);
		sum_of = {1'b0, al, pgood_n_state, off_state, |l[31:24], |l[23:16], |l[15:8], |l[7:0]};
	endfunction
	// Pulse one detector; returns once the alert path has settled
	task automatic ev(input int k);
		@(posedge core_clk) event_in[k] <= 1'b1;
		@(posedge core_clk) event_in[k] <= 1'b0;
		lat_m[k] = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	task automatic finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		finish_test();
	end

	initial begin
		srst = 1'b1;
		event_in = '0;
		off_state = 1'b0;
		pgood_n_state = 1'b0;
		lat_m = '0;
		failures = 0;
		comparisons = 0;
		void'($urandom(32'h6401));
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		#1 alert(1'b0);
		rchk(adr_summary, 8'h00);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			off_state <= 1'($urandom);
			pgood_n_state <= 1'($urandom);
			b = $urandom_range(31);
			m = 8'h01 << (b % 8);
			ev(b);
			alert(1'b1);
			rchk(4'(b / 8), m);
			rchk(adr_summary, sum_of(lat_m, 1'b1));
			hm.pulse(3'b010);
			alert(1'b0);
			hm.wr(4'(b / 8), ~m & 8'($urandom));
			rchk(4'(b / 8), m);
			hm.wr(4'(b / 8), m);
			lat_m[b] = 1'b0;
			rchk(adr_summary, sum_of(lat_m, 1'b0));
		end
		$display("test random done");
		ev(1);
		ev(3);
		hm.wr(adr_status0, 8'h02);
		lat_m[1] = 1'b0;
		hm.wr(adr_summary, 8'hff);
		rchk(adr_summary, sum_of(lat_m, 1'b1));
		hm.pulse(3'b100);
		lat_m = '0;
		alert(1'b0);
		rchk(adr_status0, 8'h00);
		$display("test group done");
		hm.wr(adr_mask1, 8'h04);
		ev(10);
		alert(1'b0);
		rchk(adr_status1, 8'h04);
		rchk(adr_mask1, 8'h04);
		event_in[10] <= 1'b1;
		hm.wr(adr_status1, 8'h04);
		rchk(adr_status1, 8'h04);
		alert(1'b0);
		event_in[10] <= 1'b0;
		hm.pulse(3'b001);
		rchk(adr_status1, 8'h00);
		event_in[17] <= 1'b1;
		repeat (3) @(posedge core_clk);
		hm.pulse(3'b010);
		hm.wr(adr_status2, 8'h02);
		repeat (2) @(posedge core_clk);
		#1 alert(1'b1);
		rchk(adr_status2, 8'h02);
		event_in[17] <= 1'b0;
		hm.pulse(3'b100);
		$display("test persist done");
		off_state <= 1'b1;
		pgood_n_state <= 1'b1;
		hm.pulse(3'b100);
		rchk(adr_summary, 8'h30);
		off_state <= 1'b0;
		pgood_n_state <= 1'b0;
		ev(5);
		hm.wr(adr_ctrl, 8'hab);
		rchk(adr_status0, 8'h00);
		alert(1'b1);
		rchk(adr_ctrl, 8'haa);
		rchk(4'hc, rd_unmapped);
		$display("test live done");
		finish_test();
	end
endmodule // status_alert_aggregator_tb_top
